// ---- pkg/sysconf_pkg.sv ----
// Contract
// - A write to the debug force-reset register from the user program bus is ignored; only debug writes count.
// - Every read of the debug force-reset register returns an all-zero byte.
// - A debug write of one to bit 0 of the force-reset register requests a full device reset.
// - A debug forced reset leaves every flag of the reset source status register cleared.
// - The system options register is always readable and its bits 3 and 2 read as zero.
// - The system options register takes only the first write after reset and ignores all later writes.
// - Options bit 7 enables the watchdog timer and resets to one.
// - Options bit 6 selects the long watchdog period when one, the short one when zero, and resets to one.
// - Options bit 5 permits stop mode, resets to zero, and while zero a stop instruction forces an illegal opcode reset.
// - Clock output control bit 4 enables the clock output on its port pin; zero disables it.
// - With a nonzero divide field the output clock runs at the bus clock divided by twice the field value.
// - With a zero divide field and the output enabled the pin is driven constantly low.
// - A read-only hard-coded 12-bit part number sits in bits 3:0 of the high and all bits of the low id register.
// - Bits 7:4 of the high id register are reserved and writes to them have no effect.
package sysconf_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [2:0] ADDR_FORCE_RESET = 3'h0;
	localparam logic [2:0] ADDR_OPTIONS     = 3'h1;
	localparam logic [2:0] ADDR_CLKOUT_CTRL = 3'h2;
	localparam logic [2:0] ADDR_ID_HIGH     = 3'h3;
	localparam logic [2:0] ADDR_ID_LOW      = 3'h4;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int FORCE_RESET_BIT  = 0;
	localparam int WDOG_ENABLE_BIT  = 7;
	localparam int WDOG_LONG_BIT    = 6;
	localparam int STOP_PERMIT_BIT  = 5;
	localparam int CLKOUT_EN_BIT    = 4;
	localparam int CLKOUT_DIV_LSB   = 0;
	localparam int CLKOUT_DIV_W     = 3;
	localparam int PART_NUMBER_W    = 12;

	// ----------------------------------------
	// Reset values and read masks
	// ----------------------------------------
	localparam logic [7:0] OPTIONS_RESET    = 8'hC0;
	localparam logic [7:0] OPTIONS_MASK     = 8'hE0;
	localparam logic [7:0] CLKOUT_RESET     = 8'h00;
	localparam logic [7:0] CLKOUT_MASK      = 8'h17;
	localparam logic [7:0] READ_ZERO        = 8'h00;
	localparam logic [3:0] ID_RESERVED_READ = 4'h0;
	// Arbitrary neutral part number
	localparam logic [11:0] PART_NUMBER_DEFAULT = 12'h5A3;

endpackage

// ---- rtl/clkout_divider.sv ----
`timescale 1ns/1ps
module clkout_divider #(
	parameter int DIV_W = sysconf_pkg::CLKOUT_DIV_W
) (
	input  wire logic             clk_i,
	input  wire logic             srst_i,
	input  wire logic             enable_i,
	input  wire logic [DIV_W-1:0] divide_i,
	output logic                  clk_out_o
);

	// ----------------------------------------
	// Half period counter
	// ----------------------------------------
	localparam logic [DIV_W-1:0] ONE  = {{(DIV_W-1){1'b0}}, 1'b1};
	localparam logic [DIV_W-1:0] ZERO = {DIV_W{1'b0}};

	logic [DIV_W-1:0] cnt_reg;
	logic             out_reg;
	logic             run;
	logic             wrap;

	assign run  = enable_i && (divide_i != ZERO);
	assign wrap = (cnt_reg >= DIV_W'(divide_i - ONE));

	always_ff @(posedge clk_i) begin
		if (srst_i || !run) begin
			cnt_reg <= ZERO;
		end else if (wrap) begin
			cnt_reg <= ZERO;
		end else begin
			cnt_reg <= DIV_W'(cnt_reg + ONE);
		end
	end

	// ----------------------------------------
	// Output toggle
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i || !run) begin
			out_reg <= 1'b0;
		end else if (wrap) begin
			out_reg <= ~out_reg;
		end
	end

	assign clk_out_o = out_reg;

endmodule

// ---- rtl/system_config_registers.sv ----
`timescale 1ns/1ps
module system_config_registers #(
	parameter logic [11:0] PART_NUMBER = sysconf_pkg::PART_NUMBER_DEFAULT
) (
	input  wire logic       clk_i,
	input  wire logic       srst_i,
	input  wire logic [2:0] cpu_addr_i,
	input  wire logic       cpu_wr_i,
	input  wire logic       cpu_rd_i,
	input  wire logic [7:0] cpu_wdata_i,
	output logic [7:0]      cpu_rdata_o,
	input  wire logic [2:0] dbg_addr_i,
	input  wire logic       dbg_wr_i,
	input  wire logic       dbg_rd_i,
	input  wire logic [7:0] dbg_wdata_i,
	output logic [7:0]      dbg_rdata_o,
	input  wire logic       stop_exec_i,
	output logic            stop_enter_o,
	output logic            illegal_opcode_reset_o,
	output logic            force_reset_o,
	output logic            reset_source_clear_o,
	output logic            watchdog_enable_o,
	output logic            watchdog_long_period_o,
	output logic            stop_permit_o,
	output logic            clock_output_port_pin_o,
	output logic            clock_output_port_pin_oe_n_o
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] options_reg;
	logic       options_locked_reg;
	logic [7:0] clkout_ctrl_reg;
	logic       force_reset_reg;
	logic       status_clear_reg;
	logic       stop_enter_reg;
	logic       illegal_reg;
	logic       oe_n_reg;
	logic [7:0] cpu_rdata_reg;
	logic [7:0] dbg_rdata_reg;
	logic       divider_out;

	// ----------------------------------------
	// Write source merge
	// ----------------------------------------
	logic       wr_any;
	logic [2:0] wr_addr;
	logic [7:0] wr_data;

	assign wr_any  = dbg_wr_i || cpu_wr_i;
	assign wr_addr = dbg_wr_i ? dbg_addr_i : cpu_addr_i;
	assign wr_data = dbg_wr_i ? dbg_wdata_i : cpu_wdata_i;

	function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
		return a == off;
	endfunction

	function automatic logic [7:0] read_value(input logic [2:0] a);
		logic [7:0] v;
		v = sysconf_pkg::READ_ZERO;
		if (hit(a, sysconf_pkg::ADDR_FORCE_RESET)) begin
			v = sysconf_pkg::READ_ZERO;
		end else if (hit(a, sysconf_pkg::ADDR_OPTIONS)) begin
			v = options_reg & sysconf_pkg::OPTIONS_MASK;
		end else if (hit(a, sysconf_pkg::ADDR_CLKOUT_CTRL)) begin
			v = clkout_ctrl_reg & sysconf_pkg::CLKOUT_MASK;
		end else if (hit(a, sysconf_pkg::ADDR_ID_HIGH)) begin
			v = {sysconf_pkg::ID_RESERVED_READ, PART_NUMBER[11:8]};
		end else if (hit(a, sysconf_pkg::ADDR_ID_LOW)) begin
			v = PART_NUMBER[7:0];
		end
		return v;
	endfunction

	// ----------------------------------------
	// Debug force reset
	// ----------------------------------------
	logic force_req;

	assign force_req = dbg_wr_i && hit(dbg_addr_i, sysconf_pkg::ADDR_FORCE_RESET)
		&& dbg_wdata_i[sysconf_pkg::FORCE_RESET_BIT];

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			force_reset_reg  <= 1'b0;
			status_clear_reg <= 1'b0;
		end else begin
			force_reset_reg  <= force_req;
			status_clear_reg <= force_req;
		end
	end

	// ----------------------------------------
	// System options, write once
	// ----------------------------------------
	logic opt_wr;

	assign opt_wr = wr_any && hit(wr_addr, sysconf_pkg::ADDR_OPTIONS);

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			options_reg        <= sysconf_pkg::OPTIONS_RESET;
			options_locked_reg <= 1'b0;
		end else if (opt_wr && !options_locked_reg) begin
			options_reg        <= wr_data & sysconf_pkg::OPTIONS_MASK;
			options_locked_reg <= 1'b1;
		end
	end

	// ----------------------------------------
	// Stop instruction handling
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			stop_enter_reg <= 1'b0;
			illegal_reg    <= 1'b0;
		end else begin
			stop_enter_reg <= stop_exec_i && options_reg[sysconf_pkg::STOP_PERMIT_BIT];
			illegal_reg    <= stop_exec_i && !options_reg[sysconf_pkg::STOP_PERMIT_BIT];
		end
	end

	// ----------------------------------------
	// Clock output control
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			clkout_ctrl_reg <= sysconf_pkg::CLKOUT_RESET;
		end else if (wr_any && hit(wr_addr, sysconf_pkg::ADDR_CLKOUT_CTRL)) begin
			clkout_ctrl_reg <= wr_data & sysconf_pkg::CLKOUT_MASK;
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			oe_n_reg <= 1'b1;
		end else begin
			oe_n_reg <= ~clkout_ctrl_reg[sysconf_pkg::CLKOUT_EN_BIT];
		end
	end

	clkout_divider #(
		.DIV_W (sysconf_pkg::CLKOUT_DIV_W)
	) u_divider (
		.clk_i     (clk_i),
		.srst_i    (srst_i),
		.enable_i  (clkout_ctrl_reg[sysconf_pkg::CLKOUT_EN_BIT]),
		.divide_i  (clkout_ctrl_reg[sysconf_pkg::CLKOUT_DIV_LSB +: sysconf_pkg::CLKOUT_DIV_W]),
		.clk_out_o (divider_out)
	);

	// ----------------------------------------
	// Read ports
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			cpu_rdata_reg <= sysconf_pkg::READ_ZERO;
		end else if (cpu_rd_i) begin
			cpu_rdata_reg <= read_value(cpu_addr_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			dbg_rdata_reg <= sysconf_pkg::READ_ZERO;
		end else if (dbg_rd_i) begin
			dbg_rdata_reg <= read_value(dbg_addr_i);
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign cpu_rdata_o                  = cpu_rdata_reg;
	assign dbg_rdata_o                  = dbg_rdata_reg;
	assign force_reset_o                = force_reset_reg;
	assign reset_source_clear_o         = status_clear_reg;
	assign stop_enter_o                 = stop_enter_reg;
	assign illegal_opcode_reset_o       = illegal_reg;
	assign watchdog_enable_o            = options_reg[sysconf_pkg::WDOG_ENABLE_BIT];
	assign watchdog_long_period_o       = options_reg[sysconf_pkg::WDOG_LONG_BIT];
	assign stop_permit_o                = options_reg[sysconf_pkg::STOP_PERMIT_BIT];
	assign clock_output_port_pin_o      = divider_out;
	assign clock_output_port_pin_oe_n_o = oe_n_reg;

	// ----------------------------------------
	// Checking helpers
	// ----------------------------------------
	logic       rst_seen_reg;
	logic       pin_prev_reg;
	logic [4:0] run_len_reg;
	logic [4:0] cfg_age_reg;
	logic [7:0] ctrl_prev_reg;
	logic [2:0] div_now;

	assign div_now = clkout_ctrl_reg[sysconf_pkg::CLKOUT_DIV_LSB +: sysconf_pkg::CLKOUT_DIV_W];

	always_ff @(posedge clk_i) begin
		rst_seen_reg  <= srst_i;
		pin_prev_reg  <= clock_output_port_pin_o;
		ctrl_prev_reg <= clkout_ctrl_reg;
		if (srst_i) begin
			run_len_reg <= 5'h00;
		end else if (clock_output_port_pin_o != pin_prev_reg) begin
			run_len_reg <= 5'h01;
		end else if (run_len_reg != 5'h1F) begin
			run_len_reg <= 5'(run_len_reg + 5'h01);
		end
		if (srst_i || clkout_ctrl_reg != ctrl_prev_reg) begin
			cfg_age_reg <= 5'h00;
		end else if (cfg_age_reg != 5'h1F) begin
			cfg_age_reg <= 5'(cfg_age_reg + 5'h01);
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (srst_i);

	chk_user_force_ignored: assert property (
		(cpu_wr_i && !dbg_wr_i) |=> !force_reset_o)
		else $error("user write forced a reset");

	chk_force_reads_zero: assert property (
		(cpu_rd_i && cpu_addr_i == sysconf_pkg::ADDR_FORCE_RESET) |=> cpu_rdata_o == 8'h00)
		else $error("force reset register read nonzero");

	chk_debug_force_reset: assert property (
		(dbg_wr_i && dbg_addr_i == sysconf_pkg::ADDR_FORCE_RESET && dbg_wdata_i[sysconf_pkg::FORCE_RESET_BIT])
		|=> force_reset_o)
		else $error("debug force reset not issued");

	chk_status_clear_pair: assert property (
		force_reset_o |-> reset_source_clear_o)
		else $error("forced reset without status clear");

	chk_options_reserved: assert property (
		(cpu_rd_i && cpu_addr_i == sysconf_pkg::ADDR_OPTIONS) |=> cpu_rdata_o[3:2] == 2'h0)
		else $error("options bits 3:2 read nonzero");

	chk_options_write_once: assert property (
		options_locked_reg |=> $stable(options_reg) && options_locked_reg)
		else $error("options changed after lock");

	chk_options_first_write: assert property (
		(!options_locked_reg && cpu_wr_i && !dbg_wr_i && cpu_addr_i == sysconf_pkg::ADDR_OPTIONS)
		|=> watchdog_enable_o == $past(cpu_wdata_i[7]) && stop_permit_o == $past(cpu_wdata_i[5]))
		else $error("first options write not taken");

	chk_options_reset_value: assert property (
		rst_seen_reg |-> watchdog_enable_o && watchdog_long_period_o && !stop_permit_o)
		else $error("options reset value wrong");

	chk_stop_illegal: assert property (
		(stop_exec_i && !stop_permit_o) |=> illegal_opcode_reset_o && !stop_enter_o)
		else $error("stop while forbidden not trapped");

	chk_clkout_enable: assert property (
		##1 clock_output_port_pin_oe_n_o == !$past(clkout_ctrl_reg[sysconf_pkg::CLKOUT_EN_BIT]))
		else $error("clock output enable mismatch");

	chk_clkout_low: assert property (
		(clkout_ctrl_reg[4] && div_now == 3'h0) [*2] |-> !clock_output_port_pin_o)
		else $error("clock output not low with zero divide");

	chk_clkout_half_period: assert property (
		(clock_output_port_pin_o != pin_prev_reg && cfg_age_reg >= 5'h10 && div_now != 3'h0)
		|-> run_len_reg == 5'(div_now))
		else $error("clock output half period wrong");

	chk_id_read: assert property (
		(cpu_rd_i && cpu_addr_i == sysconf_pkg::ADDR_ID_HIGH)
		|=> cpu_rdata_o == {4'h0, PART_NUMBER[11:8]})
		else $error("id high read wrong");

	chk_id_low_read: assert property (
		(cpu_rd_i && cpu_addr_i == sysconf_pkg::ADDR_ID_LOW) |=> cpu_rdata_o == PART_NUMBER[7:0])
		else $error("id low read wrong");

	chk_dbg_id_high: assert property (
		(dbg_rd_i && dbg_addr_i == sysconf_pkg::ADDR_ID_HIGH) |=> dbg_rdata_o[3:0] == PART_NUMBER[11:8])
		else $error("debug id high read wrong");

	chk_dbg_force_zero: assert property (
		(dbg_rd_i && dbg_addr_i == sysconf_pkg::ADDR_FORCE_RESET) |=> dbg_rdata_o == sysconf_pkg::READ_ZERO)
		else $error("debug read of force reset nonzero");

	chk_stop_permitted: assert property (
		(stop_exec_i && stop_permit_o) |=> stop_enter_o && !illegal_opcode_reset_o)
		else $error("permitted stop not entered");

	chk_clkout_off_low: assert property (
		!clkout_ctrl_reg[sysconf_pkg::CLKOUT_EN_BIT] |=> !clock_output_port_pin_o)
		else $error("clock output active while disabled");

	chk_clear_only_forced: assert property (
		reset_source_clear_o |-> force_reset_o)
		else $error("status clear without forced reset");

	cov_debug_reset: cover property (force_reset_o);
	cov_options_locked_rewrite: cover property (options_locked_reg && cpu_wr_i && cpu_addr_i == sysconf_pkg::ADDR_OPTIONS);
	cov_stop_trap: cover property (illegal_opcode_reset_o);
	cov_clkout_toggle: cover property (clock_output_port_pin_o && !pin_prev_reg && cfg_age_reg >= 5'h10);

endmodule

// ---- verif/dbg_host_model.sv ----
`timescale 1ns/1ps
module dbg_host_model (
	input  wire logic       clk_i,
	input  wire logic       go_i,
	input  wire logic       wr_i,
	input  wire logic [2:0] addr_i,
	input  wire logic [7:0] data_i,
	output logic [2:0]      dbg_addr_o = 3'h0,
	output logic            dbg_wr_o = 1'b0,
	output logic            dbg_rd_o = 1'b0,
	output logic [7:0]      dbg_wdata_o = 8'h00
);
	// ----------------------------------------
	// One-cycle background memory command
	// ----------------------------------------
	always @(posedge clk_i) begin
		dbg_wr_o <= go_i & wr_i;
		dbg_rd_o <= go_i & ~wr_i;
		if (go_i) begin
			dbg_addr_o  <= addr_i;
			dbg_wdata_o <= data_i;
		end else begin
			// Released lines do not keep the last value
			dbg_addr_o  <= ~dbg_addr_o;
			dbg_wdata_o <= ~dbg_wdata_o;
		end
	end
endmodule

// ---- verif/test_system_config_registers.sv ----
`timescale 1ns/1ps
module test_system_config_registers;
	// Arbitrary part number
	localparam logic [11:0] PART = 12'h6B4;
	logic       clk_i, srst_i = 1'b1, cpu_wr_i = 1'b0, cpu_rd_i = 1'b0, stop_exec_i = 1'b0;
	logic [2:0] cpu_addr_i = 3'h0, h_addr = 3'h0;
	logic [7:0] cpu_wdata_i = 8'h00, h_data = 8'h00, cpu_rdata_o, dbg_rdata_o, v;
	logic       go = 1'b0, h_wr = 1'b0, crd_d = 1'b0, drd_d = 1'b0;
	logic [2:0] dbg_addr_i;
	logic [7:0] dbg_wdata_i;
	logic       dbg_wr_i, dbg_rd_i, stop_enter_o, illegal_opcode_reset_o, force_reset_o, reset_source_clear_o;
	logic       watchdog_enable_o, watchdog_long_period_o, stop_permit_o, pin, oe_n;
	logic [7:0] cq[$], dq[$];
	logic [31:0] seed = 32'd91427;
	int         bad_count = 0, total_checks = 0, n;

	system_config_registers #(.PART_NUMBER(PART)) u_system_config_registers (.clk_i(clk_i), .srst_i(srst_i),
		.cpu_addr_i(cpu_addr_i), .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_wdata_i(cpu_wdata_i),
		.cpu_rdata_o(cpu_rdata_o), .dbg_addr_i(dbg_addr_i), .dbg_wr_i(dbg_wr_i), .dbg_rd_i(dbg_rd_i),
		.dbg_wdata_i(dbg_wdata_i), .dbg_rdata_o(dbg_rdata_o), .stop_exec_i(stop_exec_i),
		.stop_enter_o(stop_enter_o), .illegal_opcode_reset_o(illegal_opcode_reset_o),
		.force_reset_o(force_reset_o), .reset_source_clear_o(reset_source_clear_o),
		.watchdog_enable_o(watchdog_enable_o), .watchdog_long_period_o(watchdog_long_period_o),
		.stop_permit_o(stop_permit_o), .clock_output_port_pin_o(pin), .clock_output_port_pin_oe_n_o(oe_n));
	dbg_host_model u_dbg_host_model (.clk_i(clk_i), .go_i(go), .wr_i(h_wr), .addr_i(h_addr), .data_i(h_data),
		.dbg_addr_o(dbg_addr_i), .dbg_wr_o(dbg_wr_i), .dbg_rd_o(dbg_rd_i), .dbg_wdata_o(dbg_wdata_i));

	// ----------------------------------------
	// Clock, helpers
	// ----------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic rst();
		@(posedge clk_i);
		srst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
	endtask
	task automatic cwr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_i);
		cpu_addr_i  <= a;
		cpu_wdata_i <= d;
		cpu_wr_i    <= 1'b1;
		@(posedge clk_i);
		cpu_wr_i    <= 1'b0;
		#1;
	endtask
	task automatic crd(input logic [2:0] a, input logic [7:0] e);
		cq.push_back(e);
		@(posedge clk_i);
		cpu_addr_i <= a;
		cpu_rd_i   <= 1'b1;
		@(posedge clk_i);
		cpu_rd_i   <= 1'b0;
	endtask
	task automatic dreq(input logic w, input logic [2:0] a, input logic [7:0] d);
		if (!w) dq.push_back(d);
		@(posedge clk_i);
		go     <= 1'b1;
		h_wr   <= w;
		h_addr <= a;
		h_data <= d;
		@(posedge clk_i);
		go     <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask
	task automatic stop_chk(input logic ent);
		@(posedge clk_i);
		stop_exec_i <= 1'b1;
		@(posedge clk_i);
		stop_exec_i <= 1'b0;
		#1;
		chk("stop_enter", ent, stop_enter_o);
		chk("illegal_reset", !ent, illegal_opcode_reset_o);
	endtask
	task automatic meas(output int c);
		logic p;
		p = pin;
		c = 0;
		do begin
			@(posedge clk_i);
			#1;
			c++;
		end while (pin === p && c < 40);
	endtask

	// ----------------------------------------
	// Read result monitor
	// ----------------------------------------
	always @(posedge clk_i) begin
		crd_d <= cpu_rd_i;
		drd_d <= dbg_rd_i;
	end
	always @(negedge clk_i) begin
		if (crd_d) chk("cpu_rdata", cq.pop_front(), cpu_rdata_o);
		if (drd_d) chk("dbg_rdata", dq.pop_front(), dbg_rdata_o);
	end

	initial begin
		repeat (5000) @(posedge clk_i);
		bad_count++;
		summarize();
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge clk_i);
		srst_i <= 1'b0;
		#1;
		chk("reset_outs", 8'h19, {watchdog_enable_o, watchdog_long_period_o, stop_permit_o, pin, oe_n});
		crd(3'h1, 8'hC0);
		stop_chk(1'b0);
		crd(3'h3, {4'h0, PART[11:8]});
		crd(3'h4, PART[7:0]);
		cwr(3'h3, 8'hFF);
		dreq(1'b1, 3'h4, 8'h00);
		crd(3'h3, {4'h0, PART[11:8]});
		dreq(1'b0, 3'h3, {4'h0, PART[11:8]});
		crd(3'h4, PART[7:0]);
		for (int a = 5; a < 8; a++) crd(a[2:0], 8'h00);
		$display("test reset_and_id done");
		cwr(3'h0, 8'h01);
		chk("cpu_force", 8'h00, {force_reset_o, reset_source_clear_o});
		dreq(1'b1, 3'h0, 8'hFE);
		chk("dbg_zero_force", 8'h00, force_reset_o);
		dreq(1'b1, 3'h0, 8'h01);
		chk("force_pulse", 8'h03, {force_reset_o, reset_source_clear_o});
		@(posedge clk_i);
		#1;
		chk("force_end", 8'h00, {force_reset_o, reset_source_clear_o});
		crd(3'h4, PART[7:0]);
		crd(3'h0, 8'h00);
		dreq(1'b0, 3'h0, 8'h00);
		$display("test force_reset done");
		v = 8'(rnd()) | 8'h20;
		cwr(3'h1, v);
		chk("opts_out", v[7:5], {watchdog_enable_o, watchdog_long_period_o, stop_permit_o});
		crd(3'h1, v & 8'hE0);
		cwr(3'h1, ~v);
		dreq(1'b1, 3'h1, ~v);
		crd(3'h1, v & 8'hE0);
		stop_chk(1'b1);
		rst();
		crd(3'h1, 8'hC0);
		dreq(1'b1, 3'h1, 8'h00);
		chk("opts_dbg", 8'h00, {watchdog_enable_o, watchdog_long_period_o, stop_permit_o});
		crd(3'h1, 8'h00);
		$display("test options done");
		for (int d = 1; d < 8; d++) begin
			cwr(3'h2, 8'h10 | d[7:0]);
			meas(n);
			meas(n);
			chk("half_period", d[7:0], n[7:0]);
			meas(n);
			chk("duty", d[7:0], n[7:0]);
			chk("oe_n_on", 8'h00, oe_n);
		end
		cwr(3'h2, 8'h10);
		repeat (3) @(posedge clk_i);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk_i);
			#1;
			chk("pin_low", 8'h00, {pin, oe_n});
		end
		v = (8'(rnd()) & 8'hE8) | 8'h03;
		cwr(3'h2, v);
		repeat (2) @(posedge clk_i);
		#1;
		chk("oe_n_off", 8'h01, oe_n);
		crd(3'h2, v & 8'h17);
		repeat (2) @(posedge clk_i);
		$display("test clock_output done");
		summarize();
	end
endmodule
